/* File: lnk_test_pkg.sv */
// lnk_test_pkg: register map, field positions, reset values and carrier types of the link test block.
// assumes byte-wide register access at the printed addresses and a 4-channel by 4-sample frame.
package lnk_test_pkg;
   // register addresses
   localparam logic [11:0] ADDR_LANE_ENABLE = 12'h0315;
   localparam logic [11:0] ADDR_BERT_CTRL = 12'h0316;
   localparam logic [11:0] ADDR_LIMIT_LO = 12'h0317;
   localparam logic [11:0] ADDR_LIMIT_MID = 12'h0318;
   localparam logic [11:0] ADDR_LIMIT_HI = 12'h0319;
   localparam logic [11:0] ADDR_TALLY_LO = 12'h031A;
   localparam logic [11:0] ADDR_TALLY_MID = 12'h031B;
   localparam logic [11:0] ADDR_TALLY_HI = 12'h031C;
   localparam logic [11:0] ADDR_PASS = 12'h031D;
   localparam logic [11:0] ADDR_CHK_CTRL = 12'h032C;
   localparam logic [11:0] ADDR_REF_LO = 12'h032D;
   localparam logic [11:0] ADDR_REF_HI = 12'h032E;
   localparam logic [11:0] ADDR_CHK_STATUS = 12'h032F;
   // field positions
   localparam int BERT_CLEAR_BIT = 0;
   localparam int BERT_RUN_BIT = 1;
   localparam int PATTERN_LSB = 2;
   localparam int TALLY_SEL_LSB = 4;
   localparam int CHK_ENABLE_BIT = 0;
   localparam int CHK_CLEAR_BIT = 1;
   localparam int CHK_CHAN_LSB = 2;
   localparam int CHK_SAMPLE_LSB = 4;
   // reset values, tally and fill limits, sizes
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [7:0] PASS_RST = 8'hFF;
   localparam logic [23:0] TALLY_MAX = 24'hFF_FFFF;
   localparam logic [4:0] HIST_FILL = 5'h1F;
   localparam int NUM_LANES = 8;
   localparam int NUM_CHANNELS = 4;
   localparam int NUM_SAMPLES = 4;
   localparam int SAMPLE_W = 16;

   typedef enum logic [1:0]
   {
      PAT_PRBS7 = 2'b00,
      PAT_PRBS15 = 2'b01,
      PAT_PRBS31 = 2'b10
   } pattern_t;

   typedef enum logic [1:0]
   {
      BS_HOLD = 2'b00,
      BS_IDLE = 2'b01,
      BS_RUN = 2'b10
   } bert_state_t;

   typedef struct packed
   {
      logic we;
      logic re;
      logic [11:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed
   {
      logic valid;
      logic [NUM_CHANNELS-1:0][NUM_SAMPLES-1:0][SAMPLE_W-1:0] sample;
   } frame_t;
endpackage : lnk_test_pkg

/* File: prbs_lane_tx.sv */
// prbs_lane_tx: one lane of the far-side serial transmitter, a prbs source with bit-flip injection.
// assumes it shares i_mclk with the receiver; bits change just after the rising edge.
`timescale 1ns/100ps
module prbs_lane_tx (
   // clock, reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_en,
   input wire logic [1:0] i_pat,
   input wire logic i_flip,
   // lane
   output logic o_valid,
   output logic o_bit
);
   logic [30:0] hist;
   logic next_bit;
   always_comb
   begin
      case (i_pat)
         2'b00: next_bit = hist[6] ^ hist[5];
         2'b01: next_bit = hist[14] ^ hist[13];
         default: next_bit = hist[30] ^ hist[27];
      endcase
   end
   // flipped bit enters the history, so one flip costs exactly one error
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         hist <= 31'h1234_5677;
         o_valid <= 1'b0;
         o_bit <= 1'b0;
      end
      else if (i_en)
      begin
         o_valid <= 1'b1;
         o_bit <= next_bit ^ i_flip;
         hist <= {hist[29:0], next_bit ^ i_flip};
      end
      else
      begin
         // idle line toggles so a stale bit never looks like data
         o_valid <= 1'b0;
         o_bit <= ~o_bit;
      end
   end
endmodule : prbs_lane_tx

/* File: serial_link_prbs_and_sample_test.sv */
// serial_link_prbs_and_sample_test: per-lane prbs error checker and one-sample transport check.
// assumes lane bits and frames arrive synchronous to i_mclk; registers are byte wide at printed addresses.
`timescale 1ns/100ps

module serial_link_prbs_and_sample_test #(
   parameter int LANES = lnk_test_pkg::NUM_LANES
)(
   // clock, reset, enable
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // register access
   input wire lnk_test_pkg::reg_req_t i_reg,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // received lane bits
   input wire logic [LANES-1:0] i_lane_valid,
   input wire logic [LANES-1:0] i_lane_data,
   // received frame from the link receiver
   input wire lnk_test_pkg::frame_t i_frame,
   // status
   output logic [LANES-1:0] o_lane_pass_flags,
   output logic o_check_mismatch_flag
);
   logic [7:0] lane_bert_enable;
   logic [2:0] error_count_lane_select;
   logic [1:0] bert_pattern_select;
   logic bert_run;
   logic bert_clear;
   logic [23:0] bert_error_limit;
   logic [1:0] check_sample_index;
   logic [1:0] check_channel_index;
   logic check_result_clear;
   logic check_enable;
   logic [7:0] expected_sample_low;
   logic [7:0] expected_sample_high;
   lnk_test_pkg::bert_state_t bert_state;
   lnk_test_pkg::bert_state_t next_bert_state;
   logic [30:0] hist [LANES];
   logic [4:0] fill [LANES];
   logic [23:0] bert_error_tally [LANES];
   logic [23:0] sel_tally;
   logic [15:0] sel_sample;
   logic [15:0] expected_sample;

   // next bit of a self-synchronising checker; hist[0] is the newest bit
   function automatic logic prbs_predict(input logic [30:0] h, input logic [1:0] pat);
      logic p;
      p = 1'b0;
      unique case (pat)
         lnk_test_pkg::PAT_PRBS7: p = h[6] ^ h[5];
         lnk_test_pkg::PAT_PRBS15: p = h[14] ^ h[13];
         lnk_test_pkg::PAT_PRBS31: p = h[30] ^ h[27];
         default: p = 1'b0;
      endcase
      return p;
   endfunction : prbs_predict

   assign sel_tally = bert_error_tally[error_count_lane_select];
   assign expected_sample = {expected_sample_high, expected_sample_low};
   assign sel_sample = i_frame.sample[check_channel_index][check_sample_index];

   // register writes; read-only addresses ignore writes
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         lane_bert_enable <= lnk_test_pkg::BYTE_RST;
         error_count_lane_select <= 3'h0;
         bert_pattern_select <= 2'h0;
         bert_run <= 1'b0;
         bert_clear <= 1'b0;
         bert_error_limit <= 24'h00_0000;
         check_sample_index <= 2'h0;
         check_channel_index <= 2'h0;
         check_result_clear <= 1'b0;
         check_enable <= 1'b0;
         expected_sample_low <= lnk_test_pkg::BYTE_RST;
         expected_sample_high <= lnk_test_pkg::BYTE_RST;
      end
      else if (i_ce && i_reg.we)
      begin
         case (i_reg.addr)
            lnk_test_pkg::ADDR_LANE_ENABLE: lane_bert_enable <= i_reg.wdata;
            lnk_test_pkg::ADDR_BERT_CTRL:
            begin
               error_count_lane_select <= i_reg.wdata[lnk_test_pkg::TALLY_SEL_LSB +: 3];
               bert_pattern_select <= i_reg.wdata[lnk_test_pkg::PATTERN_LSB +: 2];
               bert_run <= i_reg.wdata[lnk_test_pkg::BERT_RUN_BIT];
               bert_clear <= i_reg.wdata[lnk_test_pkg::BERT_CLEAR_BIT];
            end
            lnk_test_pkg::ADDR_LIMIT_LO: bert_error_limit[7:0] <= i_reg.wdata;
            lnk_test_pkg::ADDR_LIMIT_MID: bert_error_limit[15:8] <= i_reg.wdata;
            lnk_test_pkg::ADDR_LIMIT_HI: bert_error_limit[23:16] <= i_reg.wdata;
            lnk_test_pkg::ADDR_CHK_CTRL:
            begin
               check_sample_index <= i_reg.wdata[lnk_test_pkg::CHK_SAMPLE_LSB +: 2];
               check_channel_index <= i_reg.wdata[lnk_test_pkg::CHK_CHAN_LSB +: 2];
               check_result_clear <= i_reg.wdata[lnk_test_pkg::CHK_CLEAR_BIT];
               check_enable <= i_reg.wdata[lnk_test_pkg::CHK_ENABLE_BIT];
            end
            lnk_test_pkg::ADDR_REF_LO: expected_sample_low <= i_reg.wdata;
            lnk_test_pkg::ADDR_REF_HI: expected_sample_high <= i_reg.wdata;
            default: ;
         endcase
      end
   end

   // register reads, one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         o_reg_rdata <= lnk_test_pkg::BYTE_RST;
         o_reg_rvalid <= 1'b0;
      end
      else if (i_ce)
      begin
         o_reg_rvalid <= i_reg.re;
         if (i_reg.re)
         begin
            case (i_reg.addr)
               lnk_test_pkg::ADDR_LANE_ENABLE: o_reg_rdata <= lane_bert_enable;
               lnk_test_pkg::ADDR_BERT_CTRL:
                  o_reg_rdata <= {1'b0, error_count_lane_select, bert_pattern_select, bert_run, bert_clear};
               lnk_test_pkg::ADDR_LIMIT_LO: o_reg_rdata <= bert_error_limit[7:0];
               lnk_test_pkg::ADDR_LIMIT_MID: o_reg_rdata <= bert_error_limit[15:8];
               lnk_test_pkg::ADDR_LIMIT_HI: o_reg_rdata <= bert_error_limit[23:16];
               lnk_test_pkg::ADDR_TALLY_LO: o_reg_rdata <= sel_tally[7:0];
               lnk_test_pkg::ADDR_TALLY_MID: o_reg_rdata <= sel_tally[15:8];
               lnk_test_pkg::ADDR_TALLY_HI: o_reg_rdata <= sel_tally[23:16];
               lnk_test_pkg::ADDR_PASS: o_reg_rdata <= 8'(o_lane_pass_flags);
               lnk_test_pkg::ADDR_CHK_CTRL:
                  o_reg_rdata <= {2'b00, check_sample_index, check_channel_index, check_result_clear, check_enable};
               lnk_test_pkg::ADDR_REF_LO: o_reg_rdata <= expected_sample_low;
               lnk_test_pkg::ADDR_REF_HI: o_reg_rdata <= expected_sample_high;
               lnk_test_pkg::ADDR_CHK_STATUS: o_reg_rdata <= {7'h00, o_check_mismatch_flag};
               default: o_reg_rdata <= lnk_test_pkg::BYTE_RST;
            endcase
         end
      end
   end

   // test state machine
   always_comb
   begin
      if (bert_clear)
         next_bert_state = lnk_test_pkg::BS_HOLD;
      else if (bert_run)
         next_bert_state = lnk_test_pkg::BS_RUN;
      else
         next_bert_state = lnk_test_pkg::BS_IDLE;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
         bert_state <= lnk_test_pkg::BS_HOLD;
      else if (i_ce)
         bert_state <= next_bert_state;
   end

   // per-lane checkers; the first 31 bits after a clear only fill the history, and a
   // pattern change mid-run shows as errors only until the history holds bits of the new pattern
   always_ff @(posedge i_mclk)
   begin
      for (int i = 0; i < LANES; i++)
      begin
         if (i_sys_rst)
         begin
            hist[i] <= 31'h0000_0000;
            fill[i] <= 5'h00;
            bert_error_tally[i] <= 24'h00_0000;
         end
         else if (i_ce)
         begin
            if (bert_state == lnk_test_pkg::BS_HOLD)
            begin
               hist[i] <= 31'h0000_0000;
               fill[i] <= 5'h00;
               bert_error_tally[i] <= 24'h00_0000;
            end
            else if (bert_state == lnk_test_pkg::BS_RUN && lane_bert_enable[i] && i_lane_valid[i])
            begin
               hist[i] <= {hist[i][29:0], i_lane_data[i]};
               if (fill[i] != lnk_test_pkg::HIST_FILL)
                  fill[i] <= fill[i] + 5'h01;
               else if (bert_pattern_select != 2'b11
                        && i_lane_data[i] != prbs_predict(hist[i], bert_pattern_select)
                        && bert_error_tally[i] != lnk_test_pkg::TALLY_MAX)
                  bert_error_tally[i] <= bert_error_tally[i] + 24'h00_0001;
            end
         end
      end
   end

   // pass flags follow the tallies only while running, so a stopped test keeps its verdict
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
         o_lane_pass_flags <= LANES'(lnk_test_pkg::PASS_RST);
      else if (i_ce)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            if (bert_state == lnk_test_pkg::BS_HOLD)
               o_lane_pass_flags[i] <= 1'b1;
            else if (bert_state == lnk_test_pkg::BS_RUN)
               o_lane_pass_flags[i] <= bert_error_tally[i] < bert_error_limit;
         end
      end
   end

   // sticky mismatch; a mismatch seen in the clearing cycle wins over the clear
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
         o_check_mismatch_flag <= 1'b0;
      else if (i_ce)
      begin
         if (check_enable && i_frame.valid && sel_sample != expected_sample)
            o_check_mismatch_flag <= 1'b1;
         else if (check_result_clear)
            o_check_mismatch_flag <= 1'b0;
      end
   end

   a_read_tally: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_ce && i_reg.re && i_reg.addr == lnk_test_pkg::ADDR_TALLY_LO
      |=> o_reg_rvalid && o_reg_rdata == $past(sel_tally[7:0]))
      else $error("tally low byte readout wrong");

   a_clear_holds: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_ce && bert_clear |=> bert_state == lnk_test_pkg::BS_HOLD)
      else $error("clear did not hold the state machine");

   a_hold_zeroes: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_ce && bert_state == lnk_test_pkg::BS_HOLD |=> sel_tally == 24'h00_0000)
      else $error("tally not zero after hold");

   a_stopped_frozen: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      bert_state == lnk_test_pkg::BS_IDLE && !i_reg.we |=> $stable(sel_tally))
      else $error("tally moved while stopped");

   a_lane_disabled: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !lane_bert_enable[error_count_lane_select] && bert_state != lnk_test_pkg::BS_HOLD && !i_reg.we
      |=> $stable(sel_tally))
      else $error("disabled lane counted errors");

   a_pattern_refused: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      bert_pattern_select == 2'b11 && bert_state == lnk_test_pkg::BS_RUN && !i_reg.we |=> $stable(sel_tally))
      else $error("unused pattern code counted errors");

   a_tally_saturates: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      sel_tally == lnk_test_pkg::TALLY_MAX && bert_state != lnk_test_pkg::BS_HOLD && !i_reg.we
      |=> sel_tally == lnk_test_pkg::TALLY_MAX)
      else $error("tally wrapped");

   a_pass_verdict: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_ce && bert_state == lnk_test_pkg::BS_RUN && !i_reg.we
      |=> o_lane_pass_flags[error_count_lane_select] == ($past(sel_tally) < bert_error_limit))
      else $error("pass flag disagrees with tally");

   a_pass_reset: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_ce && bert_state == lnk_test_pkg::BS_HOLD |=> o_lane_pass_flags == LANES'(lnk_test_pkg::PASS_RST))
      else $error("pass flags not all set in hold");

   a_mismatch_sets: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_ce && check_enable && i_frame.valid && sel_sample != expected_sample |=> o_check_mismatch_flag)
      else $error("mismatch not flagged");

   a_check_disabled: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !check_enable && !check_result_clear |=> $stable(o_check_mismatch_flag))
      else $error("result changed while check disabled");

   a_result_clear: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_ce && check_result_clear && !(check_enable && i_frame.valid) |=> !o_check_mismatch_flag)
      else $error("result not cleared");

   a_read_tally_mid: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_ce && i_reg.re && i_reg.addr == lnk_test_pkg::ADDR_TALLY_MID
      |=> o_reg_rvalid && o_reg_rdata == $past(sel_tally[15:8]))
      else $error("tally middle byte readout wrong");

   // reset still acts with the enable low, so the check is disabled there
   a_enable_freezes: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !i_ce |=> $stable(bert_state) && $stable(o_lane_pass_flags) && $stable(o_check_mismatch_flag)
      && $stable(expected_sample) && $stable(sel_tally))
      else $error("state moved while enable low");
endmodule : serial_link_prbs_and_sample_test

/* File: serial_link_prbs_and_sample_test_tb_top.sv */
// testbench of the link test block: register checks, bit error test per pattern, sample check.
// assumes the block's register map in lnk_test_pkg and prbs_lane_tx as lane source.
`timescale 1ns/100ps
module serial_link_prbs_and_sample_test_tb_top;
   logic i_mclk;
   logic i_sys_rst;
   lnk_test_pkg::reg_req_t i_reg;
   lnk_test_pkg::frame_t i_frame;
   logic [7:0] o_reg_rdata;
   logic o_reg_rvalid;
   logic [7:0] lane_valid;
   logic [7:0] lane_data;
   logic [7:0] o_lane_pass_flags;
   logic o_check_mismatch_flag;
   logic [1:0] pat;
   logic [7:0] flip;
   logic ce;
   int miscompares;
   int n_checks;

   initial
   begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end

   serial_link_prbs_and_sample_test serial_link_prbs_and_sample_test_inst (.i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst), .i_ce(ce), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
      .o_reg_rvalid(o_reg_rvalid), .i_lane_valid(lane_valid), .i_lane_data(lane_data), .i_frame(i_frame),
      .o_lane_pass_flags(o_lane_pass_flags), .o_check_mismatch_flag(o_check_mismatch_flag));

   prbs_lane_tx tx_inst [7:0] (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_en(1'b1), .i_pat(pat),
      .i_flip(flip), .o_valid(lane_valid), .o_bit(lane_data));

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      i_reg = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
      @(negedge i_mclk);
      i_reg.we = 1'b0;
      @(negedge i_mclk);
   endtask : wr

   // read one register and compare; a missing answer ends the run
   task automatic rc(input logic [11:0] a, input logic [7:0] exp);
      int n;
      i_reg = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
      @(negedge i_mclk);
      i_reg.re = 1'b0;
      n = 0;
      while (o_reg_rvalid !== 1'b1 && n < 4)
      begin
         @(negedge i_mclk);
         n++;
      end
      if (n == 4)
      begin
         miscompares++;
         wrap_up();
      end
      chk($sformatf("reg %h", a), o_reg_rdata, exp);
      @(negedge i_mclk);
   endtask : rc

   task automatic t_reset;
      for (int a = 12'h315; a < 12'h31D; a++)
         rc(12'(a), 8'h00);
      rc(lnk_test_pkg::ADDR_PASS, 8'hFF);
      for (int a = 12'h32C; a < 12'h330; a++)
         rc(12'(a), 8'h00);
      rc(12'h300, 8'h00);
      chk("pass flags", o_lane_pass_flags, 8'hFF);
   endtask : t_reset

   task automatic t_limit;
      for (int i = 0; i < 3; i++)
      begin
         wr(lnk_test_pkg::ADDR_LIMIT_LO + 12'(i), 8'(8'h11 * (i + 1)));
         rc(lnk_test_pkg::ADDR_LIMIT_LO + 12'(i), 8'(8'h11 * (i + 1)));
      end
      wr(lnk_test_pkg::ADDR_TALLY_LO, 8'h55);
      rc(lnk_test_pkg::ADDR_TALLY_LO, 8'h00);
      wr(12'h300, 8'h55);
      rc(12'h300, 8'h00);
   endtask : t_limit

   // lanes 0-3 enabled; lane 2 (selected) and lane 5 (disabled) get three flips each
   task automatic t_bert(input logic [1:0] p);
      logic [7:0] e;
      e = (p == 2'b11) ? 8'h00 : 8'h03;
      pat = p;
      wr(lnk_test_pkg::ADDR_LANE_ENABLE, 8'h0F);
      wr(lnk_test_pkg::ADDR_LIMIT_LO, 8'h03);
      wr(lnk_test_pkg::ADDR_LIMIT_MID, 8'h00);
      wr(lnk_test_pkg::ADDR_LIMIT_HI, 8'h00);
      wr(lnk_test_pkg::ADDR_BERT_CTRL, {1'b0, 3'd2, p, 2'b01});
      wr(lnk_test_pkg::ADDR_BERT_CTRL, {1'b0, 3'd2, p, 2'b10});
      repeat (40) @(negedge i_mclk);
      repeat (3)
      begin
         flip = 8'h24;
         @(negedge i_mclk);
         flip = 8'h00;
         repeat (3) @(negedge i_mclk);
      end
      rc(lnk_test_pkg::ADDR_TALLY_LO, e);
      rc(lnk_test_pkg::ADDR_TALLY_MID, 8'h00);
      rc(lnk_test_pkg::ADDR_PASS, (p == 2'b11) ? 8'hFF : 8'hFB);
      chk("pass flags", o_lane_pass_flags, (p == 2'b11) ? 8'hFF : 8'hFB);
      wr(lnk_test_pkg::ADDR_BERT_CTRL, {1'b0, 3'd5, p, 2'b10});
      rc(lnk_test_pkg::ADDR_TALLY_LO, 8'h00);
      wr(lnk_test_pkg::ADDR_BERT_CTRL, {1'b0, 3'd2, p, 2'b00});
      flip = 8'h04;
      @(negedge i_mclk);
      flip = 8'h00;
      repeat (3) @(negedge i_mclk);
      rc(lnk_test_pkg::ADDR_TALLY_LO, e);
      wr(lnk_test_pkg::ADDR_BERT_CTRL, {1'b0, 3'd2, p, 2'b01});
      // hold state is entered one edge after the write, counters clear one edge later
      @(negedge i_mclk);
      rc(lnk_test_pkg::ADDR_TALLY_LO, 8'h00);
      rc(lnk_test_pkg::ADDR_PASS, 8'hFF);
   endtask : t_bert

   // selected place is channel 2, sample 3
   task automatic frm(input logic [15:0] hit, input logic [15:0] other);
      for (int c = 0; c < 4; c++)
         for (int s = 0; s < 4; s++)
            i_frame.sample[c][s] = (c == 2 && s == 3) ? hit : other;
      i_frame.valid = 1'b1;
      @(negedge i_mclk);
      i_frame.valid = 1'b0;
      @(negedge i_mclk);
   endtask : frm

   task automatic t_sample;
      wr(lnk_test_pkg::ADDR_REF_LO, 8'h5A);
      wr(lnk_test_pkg::ADDR_REF_HI, 8'hA5);
      rc(lnk_test_pkg::ADDR_REF_LO, 8'h5A);
      rc(lnk_test_pkg::ADDR_REF_HI, 8'hA5);
      wr(lnk_test_pkg::ADDR_CHK_CTRL, 8'h39);
      rc(lnk_test_pkg::ADDR_CHK_CTRL, 8'h39);
      frm(16'hA55A, 16'h5AA5);
      rc(lnk_test_pkg::ADDR_CHK_STATUS, 8'h00);
      frm(16'h255A, 16'hA55A);
      rc(lnk_test_pkg::ADDR_CHK_STATUS, 8'h01);
      chk("mismatch flag", {7'h00, o_check_mismatch_flag}, 8'h01);
      frm(16'hA55A, 16'hA55A);
      rc(lnk_test_pkg::ADDR_CHK_STATUS, 8'h01);
      wr(lnk_test_pkg::ADDR_CHK_CTRL, 8'h3B);
      wr(lnk_test_pkg::ADDR_CHK_CTRL, 8'h39);
      rc(lnk_test_pkg::ADDR_CHK_STATUS, 8'h00);
      wr(lnk_test_pkg::ADDR_CHK_CTRL, 8'h38);
      frm(16'h0000, 16'h0000);
      rc(lnk_test_pkg::ADDR_CHK_STATUS, 8'h00);
      wr(lnk_test_pkg::ADDR_CHK_CTRL, 8'h39);
      frm(16'hA55B, 16'hA55A);
      rc(lnk_test_pkg::ADDR_CHK_STATUS, 8'h01);
   endtask : t_sample

   // writes made while the enable is low must not land; the sticky result must survive a clear
   task automatic t_freeze;
      ce = 1'b0;
      wr(lnk_test_pkg::ADDR_REF_LO, 8'h77);
      wr(lnk_test_pkg::ADDR_CHK_CTRL, 8'h3B);
      ce = 1'b1;
      rc(lnk_test_pkg::ADDR_REF_LO, 8'h5A);
      rc(lnk_test_pkg::ADDR_CHK_CTRL, 8'h39);
      rc(lnk_test_pkg::ADDR_CHK_STATUS, 8'h01);
   endtask : t_freeze

   initial
   begin
      i_sys_rst = 1'b1;
      i_reg = '0;
      i_frame = '0;
      pat = 2'b00;
      flip = 8'h00;
      ce = 1'b1;
      miscompares = 0;
      n_checks = 0;
      repeat (8) @(negedge i_mclk);
      i_sys_rst = 1'b0;
      t_reset();
      t_limit();
      for (int p = 0; p < 4; p++)
         t_bert(2'(p));
      t_sample();
      t_freeze();
      wrap_up();
   end
endmodule : serial_link_prbs_and_sample_test_tb_top
